// *** hw/tsln_bar.sv ***
// Bar-graph source word check: hex and negative detection
module tsln_bar (
   input wire logic [15:0] src,
   input wire logic sign_disp,
   output logic visible,
   output logic zero_graph,
   output logic stars,
   output logic negative
);
   logic hex;

   always_comb begin
      negative = (src[15:12] == 4'hf);
      hex = (src[11:8] > 4'h9) || (src[7:4] > 4'h9) || (src[3:0] > 4'h9)
         || ((src[15:12] > 4'h9) && !negative);
      visible = !hex; // RULE_01
      zero_graph = visible && negative && !sign_disp; // RULE_02
      stars = zero_graph; // RULE_02
   end
endmodule : tsln_bar

// *** hw/tsln_defines.svh ***
// Offsets, field positions, reset values and timing counts of the block
`ifndef TSLN_DEFINES_SVH
`define TSLN_DEFINES_SVH

`define TSLN_AW 8
`define TSLN_NLAMP 8
`define TSLN_NSW 8

`define TSLN_OFF_CTRL 8'h00
`define TSLN_OFF_LAMP 8'h04
`define TSLN_OFF_ATTR 8'h08
`define TSLN_OFF_SWFUNC 8'h0c
`define TSLN_OFF_SWBIT 8'h10
`define TSLN_OFF_HOSTWORD 8'h14
`define TSLN_OFF_NOTIFY 8'h18
`define TSLN_OFF_BARSRC 8'h1c
`define TSLN_OFF_STATUS 8'h20

`define TSLN_CTRL_V5 0
`define TSLN_CTRL_WORDMODE 1
`define TSLN_CTRL_SCREEN 2
`define TSLN_BAR_SIGN 16

`define TSLN_RST_CTRL 2'h0
`define TSLN_RST_WORD 16'h0000
`define TSLN_RST_SWBIT 32'h76543210

`define TSLN_RESP_OKAY 2'h0
`define TSLN_RESP_SLVERR 2'h2

`define TSLN_CLK_KHZ 20000
`define TSLN_FLASH_HALF_MS 500
`define TSLN_FLASH_HALF_CYC (`TSLN_FLASH_HALF_MS * `TSLN_CLK_KHZ)

`endif

// *** hw/tsln_flash.sv ***
// Flash phase generator from a slow enable divider
module tsln_flash #(
   parameter int unsigned HALF_CYC = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic phase
);
   logic [23:0] cnt_q, cnt_d;
   logic phase_q, phase_d;
   logic tick;

   always_comb begin
      tick = (cnt_q == 24'(HALF_CYC - 1));
      cnt_d = tick ? 24'h000000 : cnt_q + 24'h000001;
      phase_d = tick ? ~phase_q : phase_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 24'h000000;
         phase_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         phase_q <= phase_d;
      end
   end

   assign phase = phase_q;
endmodule : tsln_flash

// *** hw/tsln_pkg.sv ***
// Types shared by the touch-switch and lamp notify block
package tsln_pkg;
   typedef enum logic [1:0] {
      op_mom = 2'h0,
      op_alt = 2'h1,
      op_set = 2'h2,
      op_rst = 2'h3
   } tsln_op_t;
endpackage : tsln_pkg

// *** hw/tsln_top.sv ***
// Lamp, touch-switch lighting and notify logic with AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`include "tsln_defines.svh"

// Contract
// (RULE_01) Hex bar source word hides the bar
// (RULE_02) Top digit F unsigned: 0 %, stars
// (RULE_03) Lamp unlit at 0, lit at 1
// (RULE_04) Lamp attribute picks steady or flashing
// (RULE_05) Bit index spans 00 to 15
// (RULE_06) Notify switch: press notifies, lamp bit lights
// (RULE_07) Non-notify switch drives no notify bit
// (RULE_08) Four op types on v5, momentary on v4
// (RULE_09) Momentary: 1 while held, 0 on release
// (RULE_10) Alternate inverts bit each press
// (RULE_11) Set drives bit to 1
// (RULE_12) Reset drives bit to 0
// (RULE_13) Word-mode momentary clears other word bits
// (RULE_14) Word-mode others build from captured copy
// (RULE_15) Screen change reports held momentary as 0
// (RULE_16) Host should not mix momentary in one word
// (RULE_17) Bit mode changes only its own bit
// (RULE_18) Switch unlit at 0, lit or flashing at 1
// (RULE_19) Alternate toggles from last known bit value
// (RULE_20) Lamp bits resampled continuously while shown
module tsln_top #(
   parameter int unsigned FLASH_HALF_CYC = `TSLN_FLASH_HALF_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`TSLN_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`TSLN_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [`TSLN_NSW-1:0] sw_press,
   output logic [`TSLN_NLAMP-1:0] lamp_out,
   output logic [`TSLN_NSW-1:0] sw_lit,
   output logic [15:0] notify_word,
   output logic [15:0] notify_mask,
   output logic notify_wr,
   output logic bar_visible,
   output logic bar_zero,
   output logic bar_stars
);
   localparam int NS = `TSLN_NSW;

   // Register state
   logic [1:0] ctrl_q, ctrl_d;
   logic [15:0] lamp_q, lamp_d, attr_q, attr_d;
   logic [31:0] swfunc_q, swfunc_d, swbit_q, swbit_d, barsrc_q, barsrc_d;
   logic [15:0] host_q, host_d, cap_q, cap_d;
   // AXI state
   logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
   logic rvalid_q, rvalid_d;
   logic [`TSLN_AW-1:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   // Switch and output state
   logic [NS-1:0] prev_q, prev_d, held_q, held_d;
   logic [15:0] nword_q, nword_d, nmask_q, nmask_d;
   logic nwr_q, nwr_d;
   logic [`TSLN_NLAMP-1:0] lamp_out_q, lamp_out_d;
   logic [NS-1:0] sw_lit_q, sw_lit_d;
   logic bar_vis_q, bar_zero_q, bar_stars_q, bar_neg_q;
   logic bar_vis_c, bar_zero_c, bar_stars_c, bar_neg_c;
   logic phase, do_wr, scr_c, wr_host, ar_ok;
   logic [31:0] rd_c, wval;
   logic rd_hit, wr_hit;

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] dat, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int k = 0; k < 4; k++) begin
         if (strb[k]) begin
            r[8*k +: 8] = dat[8*k +: 8];
         end
      end
      return r;
   endfunction : merge

   tsln_flash #(
      .HALF_CYC(FLASH_HALF_CYC)
   ) u_flash (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase(phase)
   );

   tsln_bar u_bar (
      .src(barsrc_q[15:0]),
      .sign_disp(barsrc_q[`TSLN_BAR_SIGN]),
      .visible(bar_vis_c),
      .zero_graph(bar_zero_c),
      .stars(bar_stars_c),
      .negative(bar_neg_c)
   );

   // AXI handshake: both halves captured, write done the cycle after
   assign s_axi_awready = ~aw_have_q & ~bvalid_q;
   assign s_axi_wready = ~w_have_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign ar_ok = s_axi_arvalid & ~rvalid_q;
   assign do_wr = aw_have_q & w_have_q & ~bvalid_q;

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (do_wr) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? `TSLN_RESP_OKAY : `TSLN_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // Register writes; device notify write to the host word wins
   always_comb begin
      ctrl_d = ctrl_q;
      lamp_d = lamp_q;
      attr_d = attr_q;
      swfunc_d = swfunc_q;
      swbit_d = swbit_q;
      barsrc_d = barsrc_q;
      wr_host = 1'b0;
      wr_hit = 1'b1;
      scr_c = 1'b0;
      wval = 32'h00000000;
      unique case (awaddr_q)
         `TSLN_OFF_CTRL: wval = merge({30'h0, ctrl_q}, wdata_q, wstrb_q);
         `TSLN_OFF_LAMP: wval = merge({16'h0, lamp_q}, wdata_q, wstrb_q);
         `TSLN_OFF_ATTR: wval = merge({16'h0, attr_q}, wdata_q, wstrb_q);
         `TSLN_OFF_SWFUNC: wval = merge(swfunc_q, wdata_q, wstrb_q);
         `TSLN_OFF_SWBIT: wval = merge(swbit_q, wdata_q, wstrb_q);
         `TSLN_OFF_HOSTWORD: wval = merge({16'h0, host_q}, wdata_q, wstrb_q);
         `TSLN_OFF_BARSRC: wval = merge(barsrc_q, wdata_q, wstrb_q);
         default: wr_hit = 1'b0;
      endcase
      if (do_wr) begin
         unique case (awaddr_q)
            `TSLN_OFF_CTRL: begin
               ctrl_d = wval[1:0];
               scr_c = wval[`TSLN_CTRL_SCREEN];
            end
            `TSLN_OFF_LAMP: lamp_d = wval[15:0]; // RULE_20
            `TSLN_OFF_ATTR: attr_d = wval[15:0];
            `TSLN_OFF_SWFUNC: swfunc_d = {8'h0, wval[23:0]};
            `TSLN_OFF_SWBIT: swbit_d = wval;
            `TSLN_OFF_HOSTWORD: wr_host = 1'b1;
            `TSLN_OFF_BARSRC: barsrc_d = {15'h0, wval[16:0]};
            default: ;
         endcase
      end
   end

   // Notify engine
   always_comb begin
      logic [3:0] b;
      logic val, fire, mom, mom_any;
      tsln_pkg::tsln_op_t op;
      b = 4'h0;
      val = 1'b0;
      fire = 1'b0;
      mom = 1'b0;
      mom_any = 1'b0;
      op = tsln_pkg::op_mom;
      prev_d = sw_press;
      held_d = held_q;
      nwr_d = 1'b0;
      nword_d = ctrl_q[`TSLN_CTRL_WORDMODE] ? cap_q : host_q; // RULE_14
      nmask_d = 16'h0000;
      for (int i = 0; i < NS; i++) begin
         b = swbit_q[4*i +: 4]; // RULE_05
         op = ctrl_q[`TSLN_CTRL_V5] ? // RULE_08
            tsln_pkg::tsln_op_t'(swfunc_q[8+2*i +: 2]) : tsln_pkg::op_mom;
         fire = 1'b0;
         val = 1'b0;
         mom = 1'b0;
         if (swfunc_q[i]) begin // RULE_07
            if (scr_c && held_q[i]) begin
               fire = 1'b1; // RULE_15
               mom = 1'b1;
               held_d[i] = 1'b0;
            end else if (sw_press[i] && !prev_q[i]) begin
               fire = 1'b1; // RULE_06
               unique case (op)
                  tsln_pkg::op_mom: begin
                     val = 1'b1; // RULE_09
                     mom = 1'b1;
                     held_d[i] = 1'b1;
                  end
                  tsln_pkg::op_alt: val = ~nword_d[b]; // RULE_10 RULE_19
                  tsln_pkg::op_set: val = 1'b1; // RULE_11
                  tsln_pkg::op_rst: val = 1'b0; // RULE_12
               endcase
            end else if (!sw_press[i] && prev_q[i] && held_q[i]) begin
               fire = 1'b1; // RULE_09
               mom = 1'b1;
               held_d[i] = 1'b0;
            end
         end
         if (fire) begin
            if (ctrl_q[`TSLN_CTRL_WORDMODE]) begin
               if (mom) begin
                  nword_d = 16'h0000; // RULE_13
               end
               nmask_d = 16'hffff;
            end else begin
               nmask_d[b] = 1'b1; // RULE_17
            end
            nword_d[b] = val;
            nwr_d = 1'b1;
            mom_any = mom_any | mom;
         end
      end
      // A press in the screen cycle keeps its hold: set wins
      if (scr_c) begin
         held_d = held_d & ~held_q;
      end
      if (!nwr_d) begin
         nword_d = nword_q;
         nmask_d = nmask_q;
      end
      host_d = nwr_d ? nword_d : (wr_host ? wval[15:0] : host_q);
      cap_d = cap_q;
      if (scr_c) begin
         cap_d = host_q; // RULE_14
      end else if (nwr_d && ctrl_q[`TSLN_CTRL_WORDMODE] && !mom_any) begin
         cap_d = nword_d;
      end
   end

   // Lighting: steady, or gated by the flash phase
   always_comb begin
      lamp_out_d = lamp_q[7:0] // RULE_03 RULE_04
         & (~attr_q[7:0] | {8{phase}});
      sw_lit_d = lamp_q[15:8] // RULE_06 RULE_18
         & (~attr_q[15:8] | {8{phase}});
   end

   // Read path
   always_comb begin
      rd_hit = 1'b1;
      rd_c = 32'h00000000;
      unique case (s_axi_araddr)
         `TSLN_OFF_CTRL: rd_c = {30'h0, ctrl_q};
         `TSLN_OFF_LAMP: rd_c = {16'h0, lamp_q};
         `TSLN_OFF_ATTR: rd_c = {16'h0, attr_q};
         `TSLN_OFF_SWFUNC: rd_c = swfunc_q;
         `TSLN_OFF_SWBIT: rd_c = swbit_q;
         `TSLN_OFF_HOSTWORD: rd_c = {16'h0, host_q};
         `TSLN_OFF_NOTIFY: rd_c = {nmask_q, nword_q};
         `TSLN_OFF_BARSRC: rd_c = barsrc_q;
         `TSLN_OFF_STATUS: rd_c = {12'h0, bar_neg_q, bar_stars_q, bar_zero_q,
            bar_vis_q, sw_lit_q, lamp_out_q};
         default: rd_hit = 1'b0;
      endcase
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (ar_ok) begin
         rvalid_d = 1'b1;
         rdata_d = rd_c;
         rresp_d = rd_hit ? `TSLN_RESP_OKAY : `TSLN_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `TSLN_RST_CTRL;
         lamp_q <= 16'h0000;
         attr_q <= 16'h0000;
         swfunc_q <= 32'h00000000;
         swbit_q <= `TSLN_RST_SWBIT;
         barsrc_q <= 32'h00000000;
         host_q <= `TSLN_RST_WORD;
         cap_q <= `TSLN_RST_WORD;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         rdata_q <= 32'h00000000;
         bresp_q <= `TSLN_RESP_OKAY;
         rresp_q <= `TSLN_RESP_OKAY;
         prev_q <= '0;
         held_q <= '0;
         nword_q <= `TSLN_RST_WORD;
         nmask_q <= 16'h0000;
         nwr_q <= 1'b0;
         lamp_out_q <= '0;
         sw_lit_q <= '0;
         bar_vis_q <= 1'b0;
         bar_zero_q <= 1'b0;
         bar_stars_q <= 1'b0;
         bar_neg_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         lamp_q <= lamp_d;
         attr_q <= attr_d;
         swfunc_q <= swfunc_d;
         swbit_q <= swbit_d;
         barsrc_q <= barsrc_d;
         host_q <= host_d;
         cap_q <= cap_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         bvalid_q <= bvalid_d;
         rvalid_q <= rvalid_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         rdata_q <= rdata_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
         prev_q <= prev_d;
         held_q <= held_d;
         nword_q <= nword_d;
         nmask_q <= nmask_d;
         nwr_q <= nwr_d;
         lamp_out_q <= lamp_out_d;
         sw_lit_q <= sw_lit_d;
         bar_vis_q <= bar_vis_c;
         bar_zero_q <= bar_zero_c;
         bar_stars_q <= bar_stars_c;
         bar_neg_q <= bar_neg_c;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign lamp_out = lamp_out_q;
   assign sw_lit = sw_lit_q;
   assign notify_word = nword_q;
   assign notify_mask = nmask_q;
   assign notify_wr = nwr_q;
   assign bar_visible = bar_vis_q;
   assign bar_zero = bar_zero_q;
   assign bar_stars = bar_stars_q;

   // Checks on switch 0 alone, so other switches cannot mask a slip
   logic solo0, press0, hex_c;
   logic [3:0] b0;
   logic [1:0] op0;
   assign solo0 = swfunc_q[0] && !scr_c && (sw_press[7:1] == prev_q[7:1]);
   assign press0 = solo0 && sw_press[0] && !prev_q[0];
   assign b0 = swbit_q[3:0];
   assign op0 = ctrl_q[`TSLN_CTRL_V5] ? swfunc_q[9:8] : 2'h0;
   assign hex_c = (barsrc_q[3:0] > 4'h9) || (barsrc_q[7:4] > 4'h9)
      || (barsrc_q[11:8] > 4'h9);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_bar_hex_hidden: assert property (hex_c |=> !bar_vis_q) // RULE_01
      else $error("bar shown with hex source");
   a_bar_neg_stars: assert property ((barsrc_q[15:12] == 4'hf) // RULE_02
      && !barsrc_q[`TSLN_BAR_SIGN] && !hex_c |=> bar_stars_q && bar_zero_q)
      else $error("negative unsigned bar not at zero with stars");
   a_lamp_off_unlit: assert property ( // RULE_03
      ##1 (lamp_out_q & ~$past(lamp_q[7:0])) == 8'h00)
      else $error("lamp lit with control bit low");
   a_lamp_steady_on: assert property ( // RULE_04
      ##1 (($past(lamp_q[7:0]) & ~$past(attr_q[7:0])) & ~lamp_out_q) == 8'h00)
      else $error("steady lamp not lit");
   a_sw_lamp_lit: assert property ( // RULE_18
      ##1 (sw_lit_q & ~$past(lamp_q[15:8])) == 8'h00)
      else $error("switch lit with lamp bit low");
   a_quiet_no_func: assert property ((swfunc_q[7:0] == 8'h00) // RULE_07
      |=> !nwr_q)
      else $error("notify written with no notify switch");
   a_mom_held_one: assert property (press0 && op0 == 2'h0 // RULE_09
      |=> nwr_q && nword_q[$past(b0)] ##0 held_q[0])
      else $error("momentary press not reported as 1");
   a_alt_invert: assert property (press0 && op0 == 2'h1 // RULE_10
      && !ctrl_q[`TSLN_CTRL_WORDMODE]
      |=> nwr_q && nword_q[$past(b0)] == !$past(host_q[b0]))
      else $error("alternate did not invert");
   a_set_one: assert property (press0 && op0 == 2'h2 // RULE_11
      |=> nwr_q && nword_q[$past(b0)])
      else $error("set press not 1");
   a_rst_zero: assert property (press0 && op0 == 2'h3 // RULE_12
      |=> nwr_q && !nword_q[$past(b0)])
      else $error("reset press not 0");
   a_word_mom_clear: assert property (press0 && op0 == 2'h0 // RULE_13
      && ctrl_q[`TSLN_CTRL_WORDMODE]
      |=> nword_q == (16'h0001 << $past(b0)))
      else $error("word momentary kept other bits");
   a_word_from_copy: assert property (press0 && op0 == 2'h2 // RULE_14
      && ctrl_q[`TSLN_CTRL_WORDMODE]
      |=> nword_q == ($past(cap_q) | (16'h0001 << $past(b0))))
      else $error("word write not built from captured copy");
   a_bit_mask_own: assert property (press0 // RULE_17
      && !ctrl_q[`TSLN_CTRL_WORDMODE]
      |=> nmask_q == (16'h0001 << $past(b0)))
      else $error("bit mode touched other bits");
   a_screen_off: assert property (scr_c && held_q[0] && swfunc_q[0] // RULE_15
      |=> nwr_q && !nword_q[$past(b0)] ##1 !held_q[0])
      else $error("held momentary not reported off on screen change");

   c_alt_press: cover property (press0 && op0 == 2'h1);
   c_word_mom: cover property (press0 && ctrl_q[`TSLN_CTRL_WORDMODE]
      && op0 == 2'h0);
   c_screen_held: cover property (scr_c && held_q[0]);
   c_bar_stars: cover property (bar_stars_q);
endmodule : tsln_top

// *** verification/touch_switch_lamp_notify_bench.sv ***
// Self-checking bench for the lamp and touch-switch notify block
module touch_switch_lamp_notify_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, notify_wr, ld;
   logic bar_visible, bar_zero, bar_stars;
   logic [7:0] awaddr, araddr, sw_press, lamp_out, sw_lit;
   logic [31:0] wdata, rdata, seed, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] notify_word, notify_mask, ld_val, host_mem, nw, nm, h, cp;
   int n_errors, checks_done, n_notify, cyc, c0;

   tsln_top #(.FLASH_HALF_CYC(4)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sw_press(sw_press),
      .lamp_out(lamp_out), .sw_lit(sw_lit), .notify_word(notify_word),
      .notify_mask(notify_mask), .notify_wr(notify_wr),
      .bar_visible(bar_visible), .bar_zero(bar_zero), .bar_stars(bar_stars)
   );
   tsln_host host_u (
      .aclk(aclk), .aresetn(aresetn), .load(ld), .load_val(ld_val),
      .notify_word(notify_word), .notify_mask(notify_mask),
      .notify_wr(notify_wr), .mem_q(host_mem)
   );

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // Pulse seen at negedge, away from the edge that launches it
   always @(negedge aclk) begin
      if (notify_wr === 1'b1) begin
         n_notify++;
         nw = notify_word;
         nm = notify_mask;
      end
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function logic [15:0] bcd();
      logic [15:0] r;
      for (int j = 0; j < 4; j++) r[4*j+:4] = 4'(rnd() % 10);
      return r;
   endfunction : bcd
   function logic [2:0] bar_exp(input logic [16:0] v);
      logic hex;
      hex = v[3:0] > 9 || v[7:4] > 9 || v[11:8] > 9;
      hex = hex || (v[15:12] > 9 && v[15:12] != 4'hf);
      if (hex) return 3'b000;
      if (v[15:12] == 4'hf && !v[16]) return 3'b111;
      return 3'b100;
   endfunction : bar_exp

   task tally_and_finish();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task chk_resp(input logic [1:0] got, input logic [1:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t resp got %h exp %h", $time, got, exp);
      end
   endtask : chk_resp
   task settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : settle
   // Readies are sampled at negedge; they only move at rising edges
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ha, hw, hb;
      logic [1:0] rb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      n = 0;
      while (!hb && n < 100) begin
         @(negedge aclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid & bready;
         rb = bresp;
         n++;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
      if (!hb) n_errors++;
      chk_resp(rb, er);
   endtask : wr
   task rdr(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
      int n;
      logic ha, hr;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      n = 0;
      while (!hr && n < 100) begin
         @(negedge aclk);
         ha = arvalid & arready;
         hr = rvalid & rready;
         d = rdata;
         r = rresp;
         n++;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
      if (!hr) n_errors++;
   endtask : rdr
   task load_word(input logic [15:0] v);
      wr(8'h14, {16'h0000, v}, 2'h0);
      ld <= 1'b1;
      ld_val <= v;
      @(posedge aclk);
      ld <= 1'b0;
   endtask : load_word
   task wait_nt(input int c, input logic [15:0] ew, input logic [15:0] em);
      int n;
      n = 0;
      while (n_notify == c && n < 20) begin
         @(posedge aclk);
         n++;
      end
      chk(n_notify, c + 1);
      chk({nm, nw & nm}, {em, ew});
   endtask : wait_nt
   task sw(input int i, input logic lv, input logic [15:0] ew,
           input logic [15:0] em);
      c0 = n_notify;
      @(posedge aclk);
      sw_press[i] <= lv;
      wait_nt(c0, ew, em);
   endtask : sw
   // Release without a check: only momentary releases notify
   task sw_rel(input int i);
      @(posedge aclk);
      sw_press[i] <= 1'b0;
      settle(4);
   endtask : sw_rel
   task sw_quiet(input int i, input logic lv);
      c0 = n_notify;
      @(posedge aclk);
      sw_press[i] <= lv;
      settle(6);
      chk(n_notify, c0);
   endtask : sw_quiet
   // Long window so both flash phases are seen
   task lamp_chk(input logic [15:0] lb, input logic [15:0] at);
      logic [7:0] ol, al, os, as2;
      logic [31:0] ex;
      wr(8'h04, {16'h0000, lb}, 2'h0);
      wr(8'h08, {16'h0000, at}, 2'h0);
      settle(2);
      ol = 8'h00;
      al = 8'hff;
      os = 8'h00;
      as2 = 8'hff;
      repeat (64) begin
         @(negedge aclk);
         ol |= lamp_out;
         al &= lamp_out;
         os |= sw_lit;
         as2 &= sw_lit;
      end
      ex = {lb[15:8], lb[15:8] & ~at[15:8], lb[7:0], lb[7:0] & ~at[7:0]};
      chk({os, as2, ol, al}, ex);
   endtask : lamp_chk
   task bar_chk(input logic [16:0] v);
      logic [2:0] got;
      wr(8'h1c, {15'h0000, v}, 2'h0);
      settle(3);
      got = {bar_visible, bar_visible & bar_zero, bar_visible & bar_stars};
      chk(got, bar_exp(v));
   endtask : bar_chk

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, ld} = '0;
      {awaddr, araddr, sw_press, wdata, wstrb, ld_val} = '0;
      {nw, nm, n_errors, checks_done, n_notify, cyc} = '0;
      seed = 32'd89298;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(8'h00, rd, rs);
      chk(rd, 32'h0);
      rdr(8'h10, rd, rs);
      chk(rd, 32'h76543210);
      rdr(8'h24, rd, rs);
      chk_resp(rs, 2'h2);
      wr(8'h18, 32'h1, 2'h2);
      wr(8'h28, 32'h1, 2'h2);
      $display("register test done");
      lamp_chk(16'hffff, 16'h0000);
      lamp_chk(16'h5aa5, 16'h0ff0);
      repeat (3) begin
         h = 16'(rnd());
         cp = 16'(rnd());
         lamp_chk(h, cp);
      end
      $display("lamp test done");
      // Sw1 alt, sw2 set, sw3 rst, sw0/sw4 mom; sw7 has no notify
      wr(8'h0c, 32'h0000e47f, 2'h0);
      wr(8'h10, 32'h765f3210, 2'h0);
      h = 16'(rnd());
      load_word(h);
      sw(1, 1'b1, 16'h0002, 16'h0002);
      sw(1, 1'b0, 16'h0000, 16'h0002);
      wr(8'h00, 32'h1, 2'h0);
      sw(1, 1'b1, 16'h0002, 16'h0002);
      sw_rel(1);
      sw(1, 1'b1, 16'h0000, 16'h0002);
      sw_rel(1);
      repeat (2) begin
         sw(2, 1'b1, 16'h0004, 16'h0004);
         sw_rel(2);
         sw(3, 1'b1, 16'h0000, 16'h0008);
         sw_rel(3);
      end
      sw(4, 1'b1, 16'h8000, 16'h8000);
      sw(4, 1'b0, 16'h0000, 16'h8000);
      sw_quiet(7, 1'b1);
      sw_quiet(7, 1'b0);
      settle(2);
      chk(host_mem, (h & 16'h7ff1) | 16'h0004);
      rdr(8'h14, rd, rs);
      chk(rd, {16'h0000, (h & 16'h7ff1) | 16'h0004});
      $display("bit mode test done");
      wr(8'h00, 32'h3, 2'h0);
      h = 16'(rnd());
      load_word(h);
      wr(8'h00, 32'h7, 2'h0);
      settle(4);
      cp = h ^ 16'h0002;
      sw(1, 1'b1, cp, 16'hffff);
      sw_rel(1);
      load_word(16'(rnd()));
      cp = cp | 16'h0004;
      sw(2, 1'b1, cp, 16'hffff);
      sw_rel(2);
      // Momentary switch alone in the word from here on
      wr(8'h0c, 32'h0000e401, 2'h0);
      sw(0, 1'b1, 16'h0001, 16'hffff);
      c0 = n_notify;
      wr(8'h00, 32'h7, 2'h0);
      wait_nt(c0, 16'h0000, 16'hffff);
      sw_quiet(0, 1'b0);
      $display("word mode test done");
      bar_chk(17'h00999);
      bar_chk(17'h00a12);
      bar_chk(17'h0a000);
      bar_chk(17'h0f123);
      bar_chk(17'h1f123);
      repeat (6) begin
         h = bcd();
         bar_chk({seed[7], h});
      end
      $display("bar test done");
      tally_and_finish();
   end
endmodule : touch_switch_lamp_notify_bench

// *** verification/tsln_host.sv ***
// Controller memory word model taking the block's notify writes
module tsln_host (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic [15:0] notify_word,
   input wire logic [15:0] notify_mask,
   input wire logic notify_wr,
   output logic [15:0] mem_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem_d;
   always_comb begin
      mem_d = mem_q;
      if (load) begin
         // Program side changes the word, as a ladder would
         mem_d = load_val;
      end else if (notify_wr) begin
         // Only masked bits land; unmasked bits keep host data
         mem_d = (mem_q & ~notify_mask) | (notify_word & notify_mask);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_q <= 16'h0000;
      end else begin
         mem_q <= mem_d;
      end
   end
endmodule : tsln_host
